/* File: hdl/uart_sir_pkg.sv */
// Constants, configuration words and state types of the serial port.
// Assumes a single 100 MHz system clock and control words set by software.
//
// Operation
// - Transmit and receive have own enables, both set after reset.
// - Clearing global enable lets the character in flight finish.
// - Frame is start bit, data LSB first, optional parity, stop bits.
// - Five to eight data bits; even, odd, stick or no parity; 1 or 2 stops.
// - Each received character carries overrun, parity, frame, break flags.
// - Divisor is 16-bit integer plus 6-bit fraction in separate words.
// - Divisor is clock over sixteen times baud; it sets the bit period.
// - A 16x baud tick times receive sampling; sixteen ticks make a bit.
// - Divisors and line control load together only on line control write.
// - Sixteen-entry transmit and receive FIFOs; receive entries add 4 flags.
// - Enabled transmitter sends while the transmit FIFO holds data.
// - Busy from FIFO non-empty until last stop bit has left.
// - Start bit checked at eighth tick; a high there is a false start.
// - Later bits sampled every sixteenth tick, then parity checked.
// - Low stop bit is a framing error; then character is stored.
// - Normal infrared: zero is 3/16 bit high pulse, one is low.
// - Infrared encoder uses start, data and parity bits; decoded low pulses feed receiver.
// - Low-power infrared pulse lasts three low-power reference ticks.
// - Low-power tick divides the reference clock by 1 to 256.
// - After reset FIFOs are one deep until FIFO enable is set.
package uart_sir_pkg;

    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] START_SAMPLE = 4'h7;
    localparam logic [3:0] SIR_PULSE_LAST = 4'h2;
    localparam logic [1:0] LP_PULSE_TICKS = 2'h3;
    localparam logic [4:0] SIR_HOLD_TICKS = 5'h10;
    localparam logic [22:0] ACC_STEP = 23'h000040;
    localparam logic [4:0] DEPTH_FIFO = 5'h10;
    localparam logic [4:0] DEPTH_HOLD = 5'h01;
    localparam logic [2:0] WORD_BASE = 3'h4;
    localparam logic [1:0] SHIFT_BASE = 2'h3;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
        tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
        rx_state_t;

    typedef struct packed {
        logic port_global_enable;
        logic tx_enable_bit;
        logic rx_enable_bit;
        logic sir_enable;
        logic sir_lowpower;
    } port_ctl_t;

    localparam port_ctl_t CTL_RESET = 5'b01100;

    typedef struct packed {
        logic send_break;
        logic parity_en;
        logic even_sel;
        logic two_stop;
        logic fifo_enable_bit;
        logic [1:0] word_len;
        logic stick_sel;
    } line_ctl_t;

    typedef struct packed {
        logic [15:0] divisor_int_part;
        logic [5:0] divisor_frac_part;
        line_ctl_t lc;
    } line_cfg_t;

    localparam line_cfg_t LINE_RESET = 30'h0;

    typedef struct packed {
        logic overrun;
        logic brk;
        logic parity_err;
        logic frame_err;
        logic [7:0] data;
    } rx_entry_t;

endpackage

/* File: hdl/uart_with_sir_codec.sv */
// Serial transmitter and receiver with FIFOs, fractional baud generator
// and infrared pulse encoder and decoder.
// Assumes control words are written by strobes in the clk_sys domain and
// that serial_in_pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module uart_with_sir_codec
    import uart_sir_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ctl_wr,
    input wire port_ctl_t port_control_reg,
    input wire logic line_wr,
    input wire logic [15:0] divisor_integer_reg,
    input wire logic [5:0] divisor_fraction_reg,
    input wire line_ctl_t line_control_reg,
    input wire logic [7:0] lp_divisor,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output rx_entry_t rx_data,
    input wire logic rx_ready,
    output logic tx_busy,
    output logic tx_empty,
    output logic rx_full,
    output logic rx_false_start,
    input wire logic serial_in_pin,
    output logic serial_out_pin
);

    typedef struct packed {
        port_ctl_t ctl;
        line_cfg_t line;
        logic sync1;
        logic sync2;
        logic [22:0] baud_acc;
        logic [7:0] lp_cnt;
        logic [15:0][7:0] tx_mem;
        logic [3:0] tx_wp;
        logic [3:0] tx_rp;
        logic [4:0] tx_cnt;
        rx_entry_t [15:0] rx_mem;
        logic [3:0] rx_wp;
        logic [3:0] rx_rp;
        logic [4:0] rx_cnt;
        tx_state_t tx_st;
        logic [3:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_stop2;
        logic txd;
        logic [1:0] lp_left;
        logic serial_out;
        rx_state_t rx_st;
        logic [3:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_pe;
        logic rx_zero;
        logic rx_hi;
        logic [4:0] sir_hold;
        logic ovr_pend;
        logic false_start;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic baud_tick;
    logic lp_tick;
    logic rx_in;
    logic tx_on;
    logic rx_on;
    logic bit_start;
    logic tx_push;
    logic tx_pop;
    logic rx_pop;
    logic rx_push;
    logic [4:0] depth;
    logic [2:0] last_bit;
    logic [7:0] word_mask;
    logic [22:0] acc_sum;
    logic [22:0] div_full;
    rx_entry_t push_entry;

    function automatic logic par_bit(input logic [7:0] d,
                                     input line_ctl_t c);
        logic p;
        p = c.even_sel ? ^d : ~^d;
        if (c.stick_sel) begin
            p = ~c.even_sel;
        end
        return p;
    endfunction

    always_comb begin
        st_nxt = st_r;
        bit_start = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        push_entry = '0;
        baud_tick = 1'b0;
        tx_on = st_r.ctl.port_global_enable & st_r.ctl.tx_enable_bit;
        rx_on = st_r.ctl.port_global_enable & st_r.ctl.rx_enable_bit;
        depth = st_r.line.lc.fifo_enable_bit ? DEPTH_FIFO : DEPTH_HOLD;
        last_bit = WORD_BASE + {1'b0, st_r.line.lc.word_len};
        word_mask = 8'hff >> (SHIFT_BASE - st_r.line.lc.word_len);

        if (ctl_wr) begin
            st_nxt.ctl = port_control_reg;
        end
        // X16_baud_tick from a 16.6 fixed-point divisor, counted in 1/64 clocks
        div_full = {1'b0, st_r.line.divisor_int_part,
                    st_r.line.divisor_frac_part};
        acc_sum = st_r.baud_acc + ACC_STEP;
        if (div_full == 23'h0) begin
            st_nxt.baud_acc = 23'h0;
        end else if (acc_sum >= div_full) begin
            baud_tick = 1'b1;
            st_nxt.baud_acc = acc_sum - div_full;
        end else begin
            st_nxt.baud_acc = acc_sum;
        end
        if (line_wr) begin
            st_nxt.line = {divisor_integer_reg, divisor_fraction_reg,
                           line_control_reg};
            st_nxt.baud_acc = 23'h0;
        end
        // Low-power reference: divide by lp_divisor, zero meaning 256
        lp_tick = (st_r.lp_cnt == lp_divisor - 8'h01);
        st_nxt.lp_cnt = lp_tick ? 8'h00 : st_r.lp_cnt + 8'h01;

        st_nxt.sync1 = serial_in_pin;
        st_nxt.sync2 = st_r.sync1;
        // Stretch a light pulse (low input) across the sampling point
        if (!st_r.sync2) begin
            st_nxt.sir_hold = SIR_HOLD_TICKS;
        end else if (baud_tick && st_r.sir_hold != 5'h0) begin
            st_nxt.sir_hold = st_r.sir_hold - 5'h01;
        end
        rx_in = st_r.ctl.sir_enable ? (st_r.sir_hold == 5'h0)
                                    : st_r.sync2;

        tx_push = tx_valid & tx_ready;
        rx_pop = rx_ready & rx_valid;
        if (tx_push) begin
            st_nxt.tx_mem[st_r.tx_wp] = tx_data;
            st_nxt.tx_wp = st_r.tx_wp + 4'h1;
        end

        case (st_r.tx_st)
            TX_IDLE: begin
                if (tx_on && st_r.tx_cnt != 5'h0) begin
                    tx_pop = 1'b1;
                    bit_start = 1'b1;
                    st_nxt.tx_sh = st_r.tx_mem[st_r.tx_rp] & word_mask;
                    st_nxt.tx_par = par_bit(st_r.tx_mem[st_r.tx_rp]
                                            & word_mask, st_r.line.lc);
                    st_nxt.tx_st = TX_START;
                    st_nxt.tx_tick = 4'h0;
                    st_nxt.tx_bit = 3'h0;
                    st_nxt.tx_stop2 = 1'b0;
                    st_nxt.txd = 1'b0;
                end else begin
                    st_nxt.txd = 1'b1;
                end
            end
            default: begin
                if (baud_tick) begin
                    st_nxt.tx_tick = st_r.tx_tick + 4'h1;
                end
                if (baud_tick && st_r.tx_tick == TICK_LAST) begin
                    bit_start = 1'b1;
                    case (st_r.tx_st)
                        TX_START: begin
                            st_nxt.tx_st = TX_DATA;
                            st_nxt.txd = st_r.tx_sh[0];
                        end
                        TX_DATA: begin
                            st_nxt.tx_sh = st_r.tx_sh >> 1;
                            st_nxt.tx_bit = st_r.tx_bit + 3'h1;
                            st_nxt.txd = st_r.tx_sh[1];
                            if (st_r.tx_bit == last_bit) begin
                                st_nxt.tx_st = st_r.line.lc.parity_en
                                               ? TX_PAR : TX_STOP;
                                st_nxt.txd = st_r.line.lc.parity_en
                                             ? st_r.tx_par : 1'b1;
                            end
                        end
                        TX_PAR: begin
                            st_nxt.tx_st = TX_STOP;
                            st_nxt.txd = 1'b1;
                        end
                        TX_STOP: begin
                            if (st_r.line.lc.two_stop && !st_r.tx_stop2) begin
                                st_nxt.tx_stop2 = 1'b1;
                            end else begin
                                st_nxt.tx_st = TX_IDLE;
                            end
                        end
                        default: st_nxt.tx_st = TX_IDLE;
                    endcase
                end
            end
        endcase
        if (tx_pop) begin
            st_nxt.tx_rp = st_r.tx_rp + 4'h1;
        end
        st_nxt.tx_cnt = st_r.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

        // Low-power pulse starts with each zero bit
        if (bit_start && !st_nxt.txd && st_nxt.tx_st != TX_IDLE) begin
            st_nxt.lp_left = LP_PULSE_TICKS;
        end else if (lp_tick && st_r.lp_left != 2'h0) begin
            st_nxt.lp_left = st_r.lp_left - 2'h1;
        end
        if (!st_nxt.ctl.sir_enable) begin
            st_nxt.serial_out = st_nxt.txd & ~st_nxt.line.lc.send_break;
        end else if (st_nxt.ctl.sir_lowpower) begin
            st_nxt.serial_out = st_nxt.lp_left != 2'h0;
        end else begin
            st_nxt.serial_out = !st_nxt.txd && st_nxt.tx_st != TX_IDLE
                                && st_nxt.tx_tick <= SIR_PULSE_LAST;
        end

        st_nxt.false_start = 1'b0;
        case (st_r.rx_st)
            RX_IDLE: begin
                st_nxt.rx_hi = rx_in;
                if (rx_on && st_r.rx_hi && !rx_in) begin
                    st_nxt.rx_st = RX_START;
                    st_nxt.rx_tick = 4'h0;
                    st_nxt.rx_bit = 3'h0;
                    st_nxt.rx_sh = 8'h00;
                    st_nxt.rx_zero = 1'b1;
                end
            end
            RX_START: begin
                if (baud_tick) begin
                    st_nxt.rx_tick = st_r.rx_tick + 4'h1;
                    if (st_r.rx_tick == START_SAMPLE) begin
                        st_nxt.rx_tick = 4'h0;
                        if (rx_in) begin
                            st_nxt.false_start = 1'b1;
                            st_nxt.rx_st = RX_IDLE;
                            st_nxt.rx_hi = 1'b1;
                        end else begin
                            st_nxt.rx_st = RX_DATA;
                        end
                    end
                end
            end
            default: begin
                if (baud_tick) begin
                    st_nxt.rx_tick = st_r.rx_tick + 4'h1;
                end
                if (baud_tick && st_r.rx_tick == TICK_LAST) begin
                    st_nxt.rx_zero = st_r.rx_zero & ~rx_in;
                    case (st_r.rx_st)
                        RX_DATA: begin
                            st_nxt.rx_sh = {rx_in, st_r.rx_sh[7:1]};
                            st_nxt.rx_bit = st_r.rx_bit + 3'h1;
                            if (st_r.rx_bit == last_bit) begin
                                st_nxt.rx_st = st_r.line.lc.parity_en
                                               ? RX_PAR : RX_STOP;
                            end
                            st_nxt.rx_pe = 1'b0;
                        end
                        RX_PAR: begin
                            st_nxt.rx_pe = rx_in != par_bit(st_r.rx_sh,
                                                            st_r.line.lc);
                            st_nxt.rx_st = RX_STOP;
                        end
                        RX_STOP: begin
                            rx_push = 1'b1;
                            push_entry.data = st_r.rx_sh
                                >> (SHIFT_BASE - st_r.line.lc.word_len);
                            push_entry.parity_err = st_r.rx_pe;
                            push_entry.frame_err = !rx_in;
                            push_entry.brk = st_r.rx_zero && !rx_in;
                            push_entry.overrun = st_r.ovr_pend;
                            st_nxt.rx_st = RX_IDLE;
                            st_nxt.rx_hi = rx_in;
                        end
                        default: st_nxt.rx_st = RX_IDLE;
                    endcase
                end
            end
        endcase

        // A full FIFO drops the character and flags the next one stored
        if (rx_push && (st_r.rx_cnt < depth || rx_pop)) begin
            st_nxt.rx_mem[st_r.rx_wp] = push_entry;
            st_nxt.rx_wp = st_r.rx_wp + 4'h1;
            st_nxt.ovr_pend = 1'b0;
        end else if (rx_push) begin
            st_nxt.ovr_pend = 1'b1;
            rx_push = 1'b0;
        end
        if (rx_pop) begin
            st_nxt.rx_rp = st_r.rx_rp + 4'h1;
        end
        st_nxt.rx_cnt = st_r.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.ctl <= CTL_RESET;
            st_r.line <= LINE_RESET;
            st_r.sync1 <= 1'b1;
            st_r.sync2 <= 1'b1;
            st_r.txd <= 1'b1;
            st_r.serial_out <= 1'b1;
            st_r.rx_zero <= 1'b1;
            st_r.tx_st <= TX_IDLE;
            st_r.rx_st <= RX_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_ready = st_r.tx_cnt < depth;
    assign tx_empty = st_r.tx_cnt == 5'h0;
    assign tx_busy = !tx_empty || st_r.tx_st != TX_IDLE;
    assign rx_valid = st_r.rx_cnt != 5'h0;
    assign rx_full = st_r.rx_cnt >= depth;
    assign rx_data = st_r.rx_mem[st_r.rx_rp];
    assign rx_false_start = st_r.false_start;
    assign serial_out_pin = st_r.serial_out;

    chk_start_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_r.tx_st == TX_START && !st_r.ctl.sir_enable |-> !serial_out_pin)
        else $error("start bit not low");
    chk_stop_high: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_r.tx_st == TX_STOP && !st_r.ctl.sir_enable
        && !st_r.line.lc.send_break |-> serial_out_pin)
        else $error("stop bit not high");
    chk_tx_launch: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_r.tx_st == TX_IDLE && tx_on && !tx_empty |=> st_r.tx_st == TX_START)
        else $error("transmitter did not start");
    chk_tx_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_r.tx_st == TX_IDLE && !tx_on |=> st_r.tx_st == TX_IDLE)
        else $error("transmit started while disabled");
    chk_busy_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !tx_empty || st_r.tx_st == TX_STOP |-> tx_busy)
        else $error("busy dropped early");
    chk_false_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_r.rx_st == RX_START && baud_tick && st_r.rx_tick == START_SAMPLE
        && rx_in |=> rx_false_start && st_r.rx_st == RX_IDLE)
        else $error("false start not flagged");
    chk_hold_depth: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !st_r.line.lc.fifo_enable_bit && $stable(st_r.line)
        |-> st_r.tx_cnt <= DEPTH_HOLD && st_r.rx_cnt <= DEPTH_HOLD)
        else $error("holding register deeper than one");
    chk_line_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !line_wr |=> $stable(st_r.line))
        else $error("divisor changed without line write");
    chk_sir_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        st_r.ctl.sir_enable && !st_r.ctl.sir_lowpower && serial_out_pin
        |-> !st_r.txd && st_r.tx_tick <= SIR_PULSE_LAST)
        else $error("infrared pulse too long");
    chk_lp_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
        bit_start && !st_nxt.txd && st_nxt.tx_st != TX_IDLE
        |=> st_r.lp_left == LP_PULSE_TICKS)
        else $error("low-power pulse not three ticks");

endmodule
`default_nettype wire

/* File: testbench/uart_far_end.sv */
// Far-end serial device: sends frames into the port, samples its output.
// Assumes a bit time of bit_cyc system clocks and an idle-high line.
`timescale 1ns/1ps
`default_nettype none
module uart_far_end (
    input wire logic clk_sys,
    input wire logic serial_out_pin,
    output logic serial_in_pin
);
    int bit_cyc = 56;
    int rx_bits = 9;
    int rx_count = 0;
    logic listen = 1'b1;
    logic [15:0] rx_word = 16'h0000;
    initial serial_in_pin = 1'b1;
    // Start bit, then n bits LSB first, then one idle bit
    task automatic drive(input logic [15:0] bits, input int n);
        @(posedge clk_sys);
        #1 serial_in_pin = 1'b0;
        repeat (bit_cyc) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            #1 serial_in_pin = bits[i];
            repeat (bit_cyc) @(posedge clk_sys);
        end
        #1 serial_in_pin = 1'b1;
        repeat (bit_cyc) @(posedge clk_sys);
    endtask
    // Infrared frame: each zero, start included, is a short low pulse
    task automatic sir(input logic [15:0] bits, input int n);
        logic [16:0] w;
        w = {bits, 1'b0};
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_sys);
            #1 serial_in_pin = w[i];
            repeat (10) @(posedge clk_sys);
            #1 serial_in_pin = 1'b1;
            repeat (bit_cyc - 11) @(posedge clk_sys);
        end
        repeat (bit_cyc) @(posedge clk_sys);
    endtask
    task automatic glitch(input int c);
        @(posedge clk_sys);
        #1 serial_in_pin = 1'b0;
        repeat (c) @(posedge clk_sys);
        #1 serial_in_pin = 1'b1;
    endtask
    // Samples every bit after the start bit at mid-bit
    always begin
        @(negedge serial_out_pin);
        if (listen) begin
            repeat (bit_cyc / 2) @(posedge clk_sys);
            for (int i = 0; i < rx_bits; i++) begin
                repeat (bit_cyc) @(posedge clk_sys);
                rx_word[i] = serial_out_pin;
            end
            rx_count++;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/uart_with_sir_codec_tb_top.sv */
// Self-checking bench for the serial port with infrared codec.
// Assumes the far-end model in uart_far_end and a 3.5 baud divisor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    checked++; \
    if ((a) !== (b)) begin \
        fails++; \
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); \
    end \
end
module uart_with_sir_codec_tb_top;
    import uart_sir_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ctl_wr = 1'b0;
    logic line_wr = 1'b0;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    port_ctl_t port_control_reg = CTL_RESET;
    line_ctl_t line_control_reg = 8'h00;
    logic [15:0] div_i = 16'h0003;
    logic [5:0] div_f = 6'h20; // Half of 64 rounded
    logic [7:0] lp_divisor = 8'h04;
    logic [7:0] tx_data = 8'h00;
    logic tx_ready, rx_valid, tx_busy, tx_empty, rx_full, rx_false_start;
    logic serial_in_pin, serial_out_pin, fs_seen;
    rx_entry_t rx_data, e;
    logic [7:0] fmts [4] = '{8'h00, 8'h52, 8'h64, 8'h47};
    logic [7:0] dm;
    logic [15:0] exp_f;
    int fails = 0, checked = 0, pulses = 0, pw = 0, cnt = 0, n, c0;
    always #5 clk_sys = ~clk_sys;
    uart_with_sir_codec uart_with_sir_codec_inst (.clk_sys(clk_sys),
        .arst_n(arst_n), .ctl_wr(ctl_wr), .port_control_reg(port_control_reg),
        .line_wr(line_wr), .divisor_integer_reg(div_i),
        .divisor_fraction_reg(div_f), .line_control_reg(line_control_reg),
        .lp_divisor(lp_divisor), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_busy(tx_busy), .tx_empty(tx_empty),
        .rx_full(rx_full), .rx_false_start(rx_false_start),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));
    uart_far_end far_end_inst (.clk_sys(clk_sys),
        .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));
    // Sticky false-start flag and infrared pulse counter
    always @(posedge clk_sys) begin
        if (rx_false_start === 1'b1) fs_seen <= 1'b1;
        if (serial_out_pin === 1'b1) cnt <= cnt + 1;
        else if (cnt != 0) begin
            pulses <= pulses + 1;
            pw <= cnt;
            cnt <= 0;
        end
    end
    task automatic ctl(input logic en, input logic sir, input logic lp);
        @(posedge clk_sys);
        #1 ctl_wr = 1'b1;
        port_control_reg = '{en, 1'b1, 1'b1, sir, lp};
        @(posedge clk_sys);
        #1 ctl_wr = 1'b0;
    endtask
    // Software clears the global enable before each call
    task automatic line(input logic [7:0] v);
        @(posedge clk_sys);
        #1 line_wr = 1'b1;
        line_control_reg = line_ctl_t'(v);
        @(posedge clk_sys);
        #1 line_wr = 1'b0;
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge clk_sys);
        #1 tx_valid = 1'b1;
        tx_data = d;
        @(negedge clk_sys);
        while (tx_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        #1 tx_valid = 1'b0;
    endtask
    task automatic pop(output rx_entry_t r);
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 3000 && rx_valid !== 1'b1; i++) @(posedge clk_sys) #1;
        r = rx_data;
        rx_ready = 1'b1;
        @(posedge clk_sys);
        #1 rx_ready = 1'b0;
    endtask
    task automatic wait_cap(input int c);
        repeat (2000) if (far_end_inst.rx_count == c) @(posedge clk_sys);
    endtask
    function automatic logic [15:0] fbits(input logic [7:0] c,
                                          input logic [7:0] d, output int k);
        int w;
        logic p;
        w = 5 + c[2:1];
        d = d & (8'hff >> (8 - w));
        p = c[0] ? ~c[5] : (c[5] ? ^d : ~^d);
        fbits = {8'h00, d};
        k = w;
        if (c[6]) begin
            fbits[k] = p;
            k++;
        end
        fbits[k] = 1'b1;
        k++;
        if (c[4]) begin
            fbits[k] = 1'b1;
            k++;
        end
    endfunction
    task automatic report_and_stop();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
    initial begin
        fs_seen = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        `CHK({serial_out_pin, tx_ready, tx_empty, tx_busy}, 4'he)
        for (int k = 0; k < 4; k++) begin
            ctl(1'b0, 1'b0, 1'b0);
            line(fmts[k]); // Divisor loads here
            ctl(1'b1, 1'b0, 1'b0);
            exp_f = fbits(fmts[k], 8'hb3, n);
            dm = 8'hb3 & (8'hff >> (2'h3 - fmts[k][2:1]));
            far_end_inst.rx_bits = n;
            c0 = far_end_inst.rx_count;
            push(8'hb3);
            wait_cap(c0);
            `CHK(far_end_inst.rx_word & ((16'h1 << n) - 1), exp_f)
            `CHK(tx_busy, 1'b1) // Last stop bit
            repeat (56) @(posedge clk_sys);
            `CHK({tx_busy, tx_empty}, 2'b01)
            far_end_inst.drive(exp_f, n);
            pop(e);
            `CHK(e, {4'h0, dm})
            if (fmts[k][6]) begin
                far_end_inst.drive(exp_f ^ (16'h1 << (5 + fmts[k][2:1])), n);
                pop(e);
                `CHK(e, {4'h2, dm})
            end
        end
        far_end_inst.drive(16'h01b3, 10);
        pop(e);
        `CHK(e, {4'h1, 8'hb3}) // Low stop
        far_end_inst.drive(16'h0000, 11);
        pop(e);
        `CHK(e.brk, 1'b1)
        far_end_inst.glitch(10);
        repeat (200) @(posedge clk_sys);
        `CHK({fs_seen, rx_valid}, 2'b10)
        ctl(1'b0, 1'b0, 1'b0);
        line(8'h06);
        far_end_inst.rx_bits = 9;
        push(8'h5a);
        repeat (2) @(posedge clk_sys);
        `CHK({tx_ready, tx_busy}, 2'b01) // One deep
        c0 = far_end_inst.rx_count;
        ctl(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk_sys);
        `CHK(serial_out_pin, 1'b0)
        ctl(1'b0, 1'b0, 1'b0);
        wait_cap(c0);
        `CHK(far_end_inst.rx_word[8:0], 9'h15a)
        line(8'h0e);
        for (int i = 0; i < 16; i++) push(8'h11 * i[7:0]);
        `CHK(tx_ready, 1'b0)
        ctl(1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            wait_cap(far_end_inst.rx_count);
            `CHK(far_end_inst.rx_word[7:0], 8'h11 * i[7:0])
        end
        for (int i = 0; i < 17; i++) far_end_inst.drive(16'h100 + 16'(i), 9);
        `CHK(rx_full, 1'b1)
        for (int i = 0; i < 16; i++) begin
            pop(e);
            `CHK(e, {4'h0, i[7:0]})
        end
        far_end_inst.drive(16'h0177, 9);
        pop(e);
        `CHK(e, {4'h8, 8'h77})
        far_end_inst.listen = 1'b0;
        // Infrared receive comes before any infrared send
        ctl(1'b0, 1'b1, 1'b0);
        ctl(1'b1, 1'b1, 1'b0);
        far_end_inst.sir(16'h01a5, 9);
        pop(e);
        `CHK(e, {4'h0, 8'ha5})
        for (int m = 0; m < 2; m++) begin
            ctl(1'b0, 1'b1, m[0]);
            ctl(1'b1, 1'b1, m[0]);
            repeat (4) @(posedge clk_sys);
            pulses = 0;
            push(8'h0f);
            repeat (700) @(posedge clk_sys);
            `CHK(pulses, 5) // Zero bits only
            if (m == 0)
                `CHK(pw >= 10 && pw <= 11, 1'b1)
            else
                `CHK(pw >= 9 && pw <= 12, 1'b1)
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
